// file: core/supervisor_reset_watchdog.sv
// supervisor core: reset generator, watchdog, margin override and ahb-lite register slave
`timescale 1ns/1ns
// How it works
// - tolerance pin low picks 5% thresholds, high picks 10% thresholds.
// - combined variant: no kick within watchdog timeout asserts reset, timer cleared.
// - combined variant: timer clears while reset asserted and on every kick edge.
// - combined variant: after reset a 54 s window waits for the first kick.
// - floating kick input disables the watchdog, no watchdog assertion at all.
// - separate-output variant: every kick edge clears the timer.
// - separate-output variant has no startup window after reset.
// - manual reset low forces reset low, held a full timeout after release.
// - timeout select high uses the internal 140 ms timeout.
// - capacitor mode timeout equals 2.06 megaohm times capacitance.
// - reset low whenever any supply is low or manual reset asserted.
// - reset releases only after a clean timeout; a new fault restarts it.
// - alarm output low while any supply is below threshold.
// - alarm output releases at once when all supplies recover.
// - with supplies good, alarm output goes low on each timer expiry.
// - alarm releases on a kick edge or manual reset low.
// - after manual reset rises, watchdog waits the reset timeout before counting.
// - margin override low forces the alarm output high.
// - margin override low holds reset and alarm outputs high whatever the supplies.
module supervisor_reset_watchdog #(
  parameter int NUM_SUPPLIES = 6,
  parameter bit SEPARATE_ALARM = 1'b0,
  parameter longint RESET_CYCLES = supervisor_pkg::RESET_TIMEOUT_CYC,
  parameter longint STARTUP_CYCLES = supervisor_pkg::STARTUP_WINDOW_CYC,
  parameter longint WDT_CYCLES = supervisor_pkg::WDT_TIMEOUT_CYC
) (
  input wire logic clk_i, // 125 MHz timebase
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [NUM_SUPPLIES-1:0] supply_low_i, // comparator says supply below threshold
  input wire logic manual_reset_n_i, // manual reset, active low
  input wire logic watchdog_kick_input_i, // kick from the host
  input wire logic watchdog_kick_open_i, // kick pin detected floating
  input wire logic threshold_tolerance_select_i, // low 5%, high 10%
  input wire logic timeout_select_input_i, // high internal timeout, low capacitor
  input wire logic margin_n_i, // margin override, active low
  input wire logic hsel_i, // ahb select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb bus ready
  output logic [31:0] hrdata_o, // ahb read data
  output logic hreadyout_o, // ahb slave ready
  output logic hresp_o, // ahb response
  output logic reset_n_o, // reset output, active low
  output logic watchdog_alarm_n_o, // separate watchdog output, active low
  output logic wide_threshold_o // threshold set select to the comparators
);

  localparam int CW = supervisor_pkg::CNT_W;
  localparam logic [CW-1:0] RESET_LIM = CW'(RESET_CYCLES);
  localparam logic [CW-1:0] STARTUP_LIM = CW'(STARTUP_CYCLES);
  localparam logic [CW-1:0] WDT_LIM = CW'(WDT_CYCLES);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  typedef enum logic [1:0] {
    R_ASSERT,
    R_WAIT,
    R_RELEASE
  } rst_state_t;

  typedef enum logic [1:0] {
    W_IDLE,
    W_STARTUP,
    W_RUN
  } wd_state_t;

  typedef struct packed {
    logic [NUM_SUPPLIES-1:0] sup_s1;
    logic [NUM_SUPPLIES-1:0] sup_s2;
    logic mrst_s1;
    logic mrst_s2;
    logic kick_s1;
    logic kick_s2;
    logic kick_s3;
    logic open_s1;
    logic open_s2;
    logic tolerance_s1;
    logic tolerance_s2;
    logic tsel_s1;
    logic tsel_s2;
    logic margin_s1;
    logic margin_s2;
    rst_state_t rst_state;
    logic [CW-1:0] rst_cnt;
    wd_state_t wd_state;
    logic [CW-1:0] wd_cnt;
    logic alarm_latch;
    logic [supervisor_pkg::CAP_W-1:0] cap_pf;
    logic wd_enable;
    logic wr_pend;
    logic [supervisor_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic reset_n;
    logic alarm_n;
    logic wide_thr;
  } state_t;

  state_t q;
  state_t next_q;

  // a counter has run its full length once it reaches limit minus one
  function automatic logic done(input logic [CW-1:0] cnt, input logic [CW-1:0] lim);
    done = (lim <= CNT_ONE) || (cnt >= lim - CNT_ONE);
  endfunction

  logic supply_fault;
  logic manual_on;
  logic margin_on;
  logic kick_edge;
  logic wd_disabled;
  logic wd_expired;
  logic wd_trip;
  logic [CW-1:0] cap_cycles;
  logic [CW-1:0] reset_lim;
  logic [CW-1:0] wd_lim;
  logic [supervisor_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] status_word;

  always_comb
  begin
    next_q = q;

    // two-flop synchronisers; the first stage feeds only the second
    next_q.sup_s1 = supply_low_i;
    next_q.sup_s2 = q.sup_s1;
    next_q.mrst_s1 = manual_reset_n_i;
    next_q.mrst_s2 = q.mrst_s1;
    next_q.kick_s1 = watchdog_kick_input_i;
    next_q.kick_s2 = q.kick_s1;
    next_q.kick_s3 = q.kick_s2;
    next_q.open_s1 = watchdog_kick_open_i;
    next_q.open_s2 = q.open_s1;
    next_q.tolerance_s1 = threshold_tolerance_select_i;
    next_q.tolerance_s2 = q.tolerance_s1;
    next_q.tsel_s1 = timeout_select_input_i;
    next_q.tsel_s2 = q.tsel_s1;
    next_q.margin_s1 = margin_n_i;
    next_q.margin_s2 = q.margin_s1;

    supply_fault = |q.sup_s2;
    manual_on = !q.mrst_s2;
    margin_on = !q.margin_s2;
    kick_edge = q.kick_s2 ^ q.kick_s3;
    wd_disabled = q.open_s2 || !q.wd_enable;

    // capacitor timeout: cycles = pF * 2.06 Mohm * 125 MHz
    cap_cycles = CW'((CW'(q.cap_pf) * CW'(supervisor_pkg::CAP_SCALE_NUM)) / CW'(supervisor_pkg::CAP_SCALE_DEN));
    reset_lim = q.tsel_s2 ? RESET_LIM : cap_cycles;

    // watchdog timer
    wd_lim = (q.wd_state == W_STARTUP) ? STARTUP_LIM : WDT_LIM;
    wd_expired = 1'b0;
    if (wd_disabled)
    begin
      // a floating kick pin freezes the timer at zero
      next_q.wd_state = W_IDLE;
      next_q.wd_cnt = '0;
    end
    else
    begin
      unique case (q.wd_state)
        W_IDLE:
        begin
          next_q.wd_cnt = '0;
          // counting starts only once reset has served its full timeout
          if (q.rst_state == R_RELEASE && !supply_fault)
          begin
            next_q.wd_state = SEPARATE_ALARM ? W_RUN : W_STARTUP;
          end
        end
        W_STARTUP, W_RUN:
        begin
          if (q.rst_state != R_RELEASE || (SEPARATE_ALARM && supply_fault))
          begin
            next_q.wd_state = W_IDLE; // cleared while reset is asserted
            next_q.wd_cnt = '0;
          end
          else if (kick_edge)
          begin
            next_q.wd_state = W_RUN; // first kick closes the startup window
            next_q.wd_cnt = '0;
          end
          else if (done(q.wd_cnt, wd_lim))
          begin
            wd_expired = 1'b1;
            next_q.wd_cnt = '0;
            next_q.wd_state = SEPARATE_ALARM ? W_RUN : W_IDLE;
          end
          else
          begin
            next_q.wd_cnt = q.wd_cnt + CNT_ONE;
          end
        end
      endcase
    end
    wd_trip = wd_expired && !SEPARATE_ALARM;

    // reset generator
    unique case (q.rst_state)
      R_ASSERT:
      begin
        next_q.rst_cnt = '0;
        if (!supply_fault && !manual_on)
        begin
          next_q.rst_state = R_WAIT;
        end
      end
      R_WAIT:
      begin
        if (supply_fault || manual_on)
        begin
          next_q.rst_state = R_ASSERT; // a new fault restarts the wait
          next_q.rst_cnt = '0;
        end
        else if (done(q.rst_cnt, reset_lim))
        begin
          next_q.rst_state = R_RELEASE;
          next_q.rst_cnt = '0;
        end
        else
        begin
          next_q.rst_cnt = q.rst_cnt + CNT_ONE;
        end
      end
      R_RELEASE:
      begin
        next_q.rst_cnt = '0;
        if (supply_fault || manual_on || wd_trip)
        begin
          next_q.rst_state = R_ASSERT;
        end
      end
    endcase

    // separate alarm: latched on expiry, dropped by a kick or manual reset
    if (!SEPARATE_ALARM || manual_on || supply_fault || wd_disabled)
    begin
      next_q.alarm_latch = 1'b0;
    end
    else if (wd_expired)
    begin
      next_q.alarm_latch = 1'b1; // a kick in the same cycle clears the timer first, so no expiry is flagged
    end
    else if (kick_edge)
    begin
      next_q.alarm_latch = 1'b0;
    end

    // outputs; margin override holds reset and alarm high
    next_q.reset_n = margin_on || (next_q.rst_state == R_RELEASE);
    if (SEPARATE_ALARM)
    begin
      // supply fault pulls it low at once and lets go with no delay
      next_q.alarm_n = margin_on || (!supply_fault && !next_q.alarm_latch);
    end
    else
    begin
      next_q.alarm_n = 1'b1;
    end
    next_q.wide_thr = q.tolerance_s2;

    // ahb-lite slave: zero wait states, always okay
    next_q.hreadyout = 1'b1;
    next_q.hresp = supervisor_pkg::HRESP_OKAY;
    if (q.wr_pend)
    begin
      unique case (q.wr_addr)
        supervisor_pkg::CAP_PF_OFFSET:
        begin
          next_q.cap_pf = hwdata_i[supervisor_pkg::CAP_W-1:0];
        end
        supervisor_pkg::WD_CTRL_OFFSET:
        begin
          next_q.wd_enable = hwdata_i[supervisor_pkg::WDC_ENABLE];
        end
        default:
        begin
          next_q.cap_pf = q.cap_pf;
        end
      endcase
    end

    status_word = '0;
    status_word[supervisor_pkg::ST_RESET_N] = q.reset_n;
    status_word[supervisor_pkg::ST_ALARM_N] = q.alarm_n;
    status_word[supervisor_pkg::ST_SUPPLY_FAULT] = supply_fault;
    status_word[supervisor_pkg::ST_MANUAL] = manual_on;
    status_word[supervisor_pkg::ST_WD_OPEN] = q.open_s2;
    status_word[supervisor_pkg::ST_STARTUP] = (q.wd_state == W_STARTUP);
    status_word[supervisor_pkg::ST_WIDE_THR] = q.tolerance_s2;
    status_word[supervisor_pkg::ST_TSEL_INT] = q.tsel_s2;
    status_word[supervisor_pkg::ST_MARGIN] = margin_on;

    rd_addr = haddr_i[supervisor_pkg::ADDR_W-1:0];
    next_q.wr_pend = 1'b0;
    next_q.hrdata = '0;
    if (hsel_i && hready_i && htrans_i == supervisor_pkg::HTRANS_NONSEQ)
    begin
      next_q.wr_pend = hwrite_i;
      next_q.wr_addr = rd_addr;
      if (!hwrite_i && haddr_i[31:supervisor_pkg::ADDR_W] == '0)
      begin
        unique case (rd_addr)
          supervisor_pkg::STATUS_OFFSET:
          begin
            next_q.hrdata = status_word;
          end
          supervisor_pkg::CAP_PF_OFFSET:
          begin
            next_q.hrdata = 32'(q.cap_pf);
          end
          supervisor_pkg::WD_CTRL_OFFSET:
          begin
            next_q.hrdata = 32'(q.wd_enable);
          end
          default:
          begin
            next_q.hrdata = '0;
          end
        endcase
      end
      else if (haddr_i[31:supervisor_pkg::ADDR_W] != '0)
      begin
        // upper address bits set: treat as unmapped, writes dropped
        next_q.wr_pend = 1'b0;
      end
    end
  end

  // hsize is accepted but only whole-word transfers are meaningful here
  logic unused_size;
  assign unused_size = ^hsize_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
      q.mrst_s1 <= 1'b1;
      q.mrst_s2 <= 1'b1;
      q.margin_s1 <= 1'b1;
      q.margin_s2 <= 1'b1;
      q.tsel_s1 <= 1'b1;
      q.tsel_s2 <= 1'b1;
      q.rst_state <= R_ASSERT;
      q.wd_state <= W_IDLE;
      q.cap_pf <= supervisor_pkg::CAP_PF_RESET;
      q.wd_enable <= supervisor_pkg::WDC_ENABLE_RESET;
      q.hreadyout <= 1'b1;
      q.hresp <= supervisor_pkg::HRESP_OKAY;
      q.reset_n <= 1'b0;
      q.alarm_n <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign hrdata_o = q.hrdata;
  assign hreadyout_o = q.hreadyout;
  assign hresp_o = q.hresp;
  assign reset_n_o = q.reset_n;
  assign watchdog_alarm_n_o = q.alarm_n;
  assign wide_threshold_o = q.wide_thr;

endmodule

// file: include/supervisor_pkg.sv
// constants for the supervisor reset and watchdog core
package supervisor_pkg;

  // timebase
  localparam longint CLK_HZ = 125_000_000;
  localparam longint CLK_MHZ = 125;

  // internal reset timeout, least value in milliseconds
  localparam longint RESET_TIMEOUT_MS = 140;
  localparam longint RESET_TIMEOUT_CYC = (RESET_TIMEOUT_MS * CLK_HZ + 999) / 1000;

  // startup window after reset, least value in seconds
  localparam longint STARTUP_WINDOW_S = 54;
  localparam longint STARTUP_WINDOW_CYC = STARTUP_WINDOW_S * CLK_HZ;

  // watchdog timeout in milliseconds, plain default
  localparam longint WDT_TIMEOUT_MS = 1000;
  localparam longint WDT_TIMEOUT_CYC = (WDT_TIMEOUT_MS * CLK_HZ) / 1000;

  // capacitor timeout: 2.06 megaohm times capacitance, resistance kept in units of 10 kohm
  localparam longint CAP_OHM_X10K = 206;
  localparam int CAP_W = 16;
  localparam longint CAP_SCALE_NUM = CAP_OHM_X10K * CLK_MHZ;
  localparam longint CAP_SCALE_DEN = 100;
  localparam logic [CAP_W-1:0] CAP_PF_RESET = 16'h0064;

  // counter width, wide enough for the startup window
  localparam int CNT_W = 34;

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CAP_PF_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] WD_CTRL_OFFSET = 8'h08;

  // status fields
  localparam int ST_RESET_N = 0;
  localparam int ST_ALARM_N = 1;
  localparam int ST_SUPPLY_FAULT = 2;
  localparam int ST_MANUAL = 3;
  localparam int ST_WD_OPEN = 4;
  localparam int ST_STARTUP = 5;
  localparam int ST_WIDE_THR = 6;
  localparam int ST_TSEL_INT = 7;
  localparam int ST_MARGIN = 8;

  // watchdog control fields
  localparam int WDC_ENABLE = 0;
  localparam logic WDC_ENABLE_RESET = 1'b1;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// file: tb/supervisor_reset_watchdog_asserts.sv
// checker for the supervisor reset and watchdog core
`timescale 1ns/1ns
module supervisor_checker #(
  parameter int NUM_SUPPLIES = 6,
  parameter bit SEPARATE_ALARM = 1'b0,
  parameter longint RESET_CYCLES = 20,
  parameter longint STARTUP_CYCLES = 60
) (
  input wire logic clk_i, // timebase
  input wire logic rst_n_i, // reset
  input wire logic [NUM_SUPPLIES-1:0] supply_low_i, // faults
  input wire logic manual_reset_n_i, // manual reset
  input wire logic watchdog_kick_input_i, // kick
  input wire logic watchdog_kick_open_i, // kick floating
  input wire logic threshold_tolerance_select_i, // tolerance
  input wire logic timeout_select_input_i, // timeout select
  input wire logic margin_n_i, // margin
  input wire logic hreadyout_o, // ready
  input wire logic hresp_o, // response
  input wire logic reset_n_o, // reset out
  input wire logic watchdog_alarm_n_o, // alarm out
  input wire logic wide_threshold_o // tolerance out
);
  int cln_c;
  int open_c;
  int idle_c;
  int low_c;
  int mrg_c;
  logic clean;
  assign clean = ~|supply_low_i & manual_reset_n_i & margin_n_i & timeout_select_input_i;
  // each count restarts when its condition breaks
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cln_c <= 0;
      open_c <= 0;
      idle_c <= 0;
      low_c <= 0;
      mrg_c <= 0;
    end
    else
    begin
      cln_c <= clean ? cln_c + 1 : 0;
      open_c <= watchdog_kick_open_i ? open_c + 1 : 0;
      idle_c <= (reset_n_o && margin_n_i && !watchdog_kick_open_i && $stable(watchdog_kick_input_i)) ? idle_c + 1 : 0;
      low_c <= reset_n_o ? 0 : low_c + 1;
      mrg_c <= margin_n_i ? mrg_c + 1 : 0;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_supply_reset: assert property ((|supply_low_i && margin_n_i) [*5] |-> !reset_n_o)
    else $error("reset high in supply fault");
  a_manual_reset: assert property ((!manual_reset_n_i && margin_n_i) [*5] |-> !reset_n_o)
    else $error("reset high in manual reset");
  a_margin_high: assert property (!margin_n_i [*5] |-> reset_n_o && watchdog_alarm_n_o)
    else $error("output low under margin");
  a_hold_time: assert property ($rose(reset_n_o) && mrg_c > RESET_CYCLES + 8 |-> low_c >= RESET_CYCLES)
    else $error("reset released early");
  a_release_time: assert property (cln_c == RESET_CYCLES + 6 |-> reset_n_o)
    else $error("reset released late");
  a_trip_bound: assert property (SEPARATE_ALARM || idle_c <= STARTUP_CYCLES + 8)
    else $error("watchdog never tripped");
  a_open_quiet: assert property ($fell(reset_n_o) |-> !(open_c > 8 && cln_c > 8))
    else $error("trip with kick pin open");
  a_thr_follow: assert property ($stable(threshold_tolerance_select_i) [*4] |->
    wide_threshold_o == threshold_tolerance_select_i)
    else $error("tolerance output wrong");
  a_alarm_supply: assert property ((|supply_low_i && margin_n_i) [*5] |-> (!SEPARATE_ALARM || !watchdog_alarm_n_o))
    else $error("alarm high in supply fault");
  a_bus_okay: assert property (hreadyout_o && hresp_o == supervisor_pkg::HRESP_OKAY)
    else $error("bus not ready or not okay");
endmodule
bind supervisor_reset_watchdog supervisor_checker #(
  .NUM_SUPPLIES(NUM_SUPPLIES), .SEPARATE_ALARM(SEPARATE_ALARM), .RESET_CYCLES(RESET_CYCLES),
  .STARTUP_CYCLES(STARTUP_CYCLES)
) i_supervisor_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low_i), .manual_reset_n_i(manual_reset_n_i),
  .watchdog_kick_input_i(watchdog_kick_input_i), .watchdog_kick_open_i(watchdog_kick_open_i),
  .threshold_tolerance_select_i(threshold_tolerance_select_i), .timeout_select_input_i(timeout_select_input_i),
  .margin_n_i(margin_n_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .reset_n_o(reset_n_o),
  .watchdog_alarm_n_o(watchdog_alarm_n_o), .wide_threshold_o(wide_threshold_o)
);

// file: tb/host_kicker.sv
// host model that services the watchdog kick pin
`timescale 1ns/1ns
module host_kicker (
  input wire logic clk_i, // clock
  input wire logic run_i, // host alive
  input wire logic [7:0] period_i, // cycles between edges
  output logic kick_o // kick pin
);
  logic [7:0] cnt = 8'h00;
  initial kick_o = 1'b0;
  // a stalled host just stops toggling, starving the watchdog
  always @(posedge clk_i)
  begin
    if (!run_i)
      cnt <= 8'h00;
    else if (cnt >= period_i - 8'h01)
    begin
      cnt <= 8'h00;
      kick_o <= ~kick_o;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// file: tb/supervisor_reset_watchdog_tb.sv
// self-checking bench for the supervisor core
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module supervisor_reset_watchdog_tb;
  localparam longint RST_CYC = 20;
  localparam int CAP_CYC = 4 * supervisor_pkg::CAP_SCALE_NUM / supervisor_pkg::CAP_SCALE_DEN;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] supply_low = 6'h00;
  logic manual_reset_n = 1'b1;
  logic kick_open = 1'b0;
  logic tolerance = 1'b0;
  logic tsel = 1'b1;
  logic margin_n = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic host_run = 1'b0;
  logic kick, hready, hresp, reset_n, alarm_n, wide_thr;
  logic hready2, reset_n2, alarm_n2;
  logic [31:0] hrdata, q;
  int failures = 0;
  int checks = 0;
  int n;
  host_kicker i_host_kicker (.clk_i(clk_i), .run_i(host_run), .period_i(8'h0A), .kick_o(kick));
  supervisor_reset_watchdog #(.RESET_CYCLES(RST_CYC), .STARTUP_CYCLES(60), .WDT_CYCLES(30))
    i_supervisor_reset_watchdog (.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low),
    .manual_reset_n_i(manual_reset_n), .watchdog_kick_input_i(kick), .watchdog_kick_open_i(kick_open),
    .threshold_tolerance_select_i(tolerance), .timeout_select_input_i(tsel), .margin_n_i(margin_n),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .reset_n_o(reset_n), .watchdog_alarm_n_o(alarm_n), .wide_threshold_o(wide_thr));
  // second copy in the separate-alarm variant sees the same pins; its bus stays idle
  supervisor_reset_watchdog #(.SEPARATE_ALARM(1'b1), .RESET_CYCLES(RST_CYC), .STARTUP_CYCLES(60), .WDT_CYCLES(30))
    i_supervisor_reset_watchdog_sep (.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_low_i(supply_low),
    .manual_reset_n_i(manual_reset_n), .watchdog_kick_input_i(kick), .watchdog_kick_open_i(kick_open),
    .threshold_tolerance_select_i(tolerance), .timeout_select_input_i(tsel), .margin_n_i(margin_n),
    .hsel_i(1'b0), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready2), .hrdata_o(), .hreadyout_o(hready2), .hresp_o(),
    .reset_n_o(reset_n2), .watchdog_alarm_n_o(alarm_n2), .wide_threshold_o());
  initial
    forever #4 clk_i = ~clk_i;
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic stuck();
    failures++;
    $display("ERROR %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (reset_n !== lvl && n < lim);
    if (reset_n !== lvl)
      stuck();
  endtask
  task automatic wait_alm(input logic lvl, input int lim);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (alarm_n2 !== lvl && n < lim);
    if (alarm_n2 !== lvl)
      stuck();
  endtask
  task automatic hold(input logic lvl, input int cyc);
    repeat (cyc)
    begin
      @(negedge clk_i);
      `CHK(reset_n, lvl)
    end
  endtask
  task automatic ready_edge();
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
      stuck();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= supervisor_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready_edge();
    q = hrdata;
  endtask
  task automatic t_startup();
    wait_lvl(1'b1, 40);
    hold(1'b1, 40);
    wait_lvl(1'b0, 40);
    wait_lvl(1'b1, 40);
    $display("startup test done");
  endtask
  task automatic t_kick();
    @(posedge clk_i);
    host_run <= 1'b1;
    hold(1'b1, 150);
    @(posedge clk_i);
    host_run <= 1'b0;
    hold(1'b1, 20);
    wait_lvl(1'b0, 30);
    @(posedge clk_i);
    host_run <= 1'b1;
    wait_lvl(1'b1, 40);
    @(posedge clk_i);
    host_run <= 1'b0;
    kick_open <= 1'b1;
    hold(1'b1, 120);
    @(posedge clk_i);
    kick_open <= 1'b0;
    host_run <= 1'b1;
    $display("kick test done");
  endtask
  task automatic t_bus();
    bus(1'b0, supervisor_pkg::CAP_PF_OFFSET, 32'h0);
    `CHK(q, {16'h0000, supervisor_pkg::CAP_PF_RESET})
    bus(1'b0, supervisor_pkg::WD_CTRL_OFFSET, 32'h0);
    `CHK(q[supervisor_pkg::WDC_ENABLE], supervisor_pkg::WDC_ENABLE_RESET)
    bus(1'b1, supervisor_pkg::CAP_PF_OFFSET, 32'h00000004);
    bus(1'b0, supervisor_pkg::CAP_PF_OFFSET, 32'h0);
    `CHK(q, 32'h00000004)
    bus(1'b1, 8'hF0, 32'hFFFFFFFF);
    bus(1'b0, 8'hF0, 32'h0);
    `CHK(q, 32'h00000000)
    @(posedge clk_i);
    tolerance <= 1'b1;
    repeat (5) @(negedge clk_i);
    `CHK(wide_thr, 1'b1)
    bus(1'b0, supervisor_pkg::STATUS_OFFSET, 32'h0);
    `CHK(q[supervisor_pkg::ST_WIDE_THR], 1'b1)
    @(posedge clk_i);
    tolerance <= 1'b0;
    repeat (5) @(negedge clk_i);
    `CHK(wide_thr, 1'b0)
    $display("bus and tolerance test done");
  endtask
  task automatic t_faults();
    @(posedge clk_i);
    supply_low <= 6'h20;
    wait_lvl(1'b0, 6);
    @(posedge clk_i);
    supply_low <= 6'h00;
    repeat (10) @(posedge clk_i);
    supply_low <= 6'h01;
    @(posedge clk_i);
    supply_low <= 6'h00;
    hold(1'b0, RST_CYC);
    wait_lvl(1'b1, 8);
    @(posedge clk_i);
    manual_reset_n <= 1'b0;
    wait_lvl(1'b0, 6);
    bus(1'b0, supervisor_pkg::STATUS_OFFSET, 32'h0);
    `CHK(q[supervisor_pkg::ST_MANUAL], 1'b1)
    manual_reset_n <= 1'b1;
    hold(1'b0, RST_CYC);
    wait_lvl(1'b1, 8);
    @(posedge clk_i);
    tsel <= 1'b0;
    supply_low <= 6'h02;
    wait_lvl(1'b0, 6);
    @(posedge clk_i);
    supply_low <= 6'h00;
    hold(1'b0, CAP_CYC);
    wait_lvl(1'b1, 8);
    @(posedge clk_i);
    tsel <= 1'b1;
    supply_low <= 6'h04;
    margin_n <= 1'b0;
    repeat (5) @(negedge clk_i);
    `CHK(reset_n, 1'b1)
    `CHK(alarm_n2, 1'b1)
    @(posedge clk_i);
    margin_n <= 1'b1;
    wait_lvl(1'b0, 6);
    @(posedge clk_i);
    supply_low <= 6'h00;
    wait_lvl(1'b1, RST_CYC + 8);
    $display("fault test done");
  endtask
  task automatic t_alarm();
    @(posedge clk_i);
    host_run <= 1'b0;
    wait_alm(1'b0, 60);
    `CHK(reset_n2, 1'b1)
    `CHK(alarm_n, 1'b1)
    @(posedge clk_i);
    host_run <= 1'b1;
    wait_alm(1'b1, 20);
    @(posedge clk_i);
    host_run <= 1'b0;
    manual_reset_n <= 1'b0;
    wait_lvl(1'b0, 6);
    `CHK(alarm_n2, 1'b1)
    @(posedge clk_i);
    manual_reset_n <= 1'b1;
    wait_lvl(1'b1, RST_CYC + 8);
    `CHK(alarm_n2, 1'b1)
    wait_alm(1'b0, 40);
    `CHK(reset_n, 1'b1)
    @(posedge clk_i);
    host_run <= 1'b1;
    wait_alm(1'b1, 20);
    @(posedge clk_i);
    supply_low <= 6'h08;
    wait_alm(1'b0, 6);
    @(posedge clk_i);
    supply_low <= 6'h00;
    wait_alm(1'b1, 6);
    `CHK(reset_n2, 1'b0)
    $display("alarm test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_startup();
    t_kick();
    t_bus();
    t_faults();
    t_alarm();
    conclude();
  end
  initial
  begin
    repeat (90000) @(posedge clk_i);
    stuck();
  end
endmodule
